// File: logic/phrase_index_unit.v
// Command interpreter for the phrase index, reached over Wishbone
//
// Added by the designer: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ns
`include "phrase_index_consts.vh"
module phrase_index_unit
#(
    parameter FREE_INIT = 8'hFE
)
(
    input wire clk_i,
    input wire rst_i,
    input wire cyc_i,
    input wire stb_i,
    input wire we_i,
    input wire [7:0] adr_i,
    input wire [3:0] sel_i,
    input wire [31:0] dat_i,
    output reg [31:0] dat_o,
    output reg ack_o,
    output wire busy_o,
    output reg active_o,
    input wire voice_i,
    input wire block_done_i,
    input wire sample_tick_i,
    input wire signed [15:0] sample_i,
    output reg signed [15:0] play_o
);
    // ==========================================================
    // States
    localparam S_IDLE = 11'h001;
    localparam S_MRD = 11'h002;
    localparam S_MRDW = 11'h004;
    localparam S_WRT = 11'h008;
    localparam S_ERALL = 11'h010;
    localparam S_DELZ = 11'h020;
    localparam S_TRIG = 11'h040;
    localparam S_REC = 11'h080;
    localparam S_RECE = 11'h100;
    localparam S_RECF = 11'h200;
    localparam S_DEL2 = 11'h400;
    // Operations waiting on a read
    localparam OP_RBLK = 3'h0;
    localparam OP_ARD = 3'h1;
    localparam OP_DEL = 3'h2;
    localparam OP_DEL2 = 3'h3;
    localparam OP_REC = 3'h4;

    reg [10:0] state;
    reg [2:0] op;
    reg [3:0] cmd;
    reg [3:0] args_left;
    reg [3:0] arg_idx;
    reg [39:0] arg;
    reg go;
    reg [1:0] cmd_set;
    reg [5:0] phrase;
    reg [7:0] target;
    reg [1:0] gain;
    reg armed;
    reg [39:0] tx_buf;
    reg [3:0] tx_left;
    reg [39:0] held;
    reg [7:0] free;
    reg [7:0] blocks;
    reg [15:0] addrc;
    reg [5:0] mem_addr;
    reg mem_we_hdr;
    reg mem_we_usr;
    reg [47:0] mem_wdata;
    wire [47:0] rdata;
    wire wb_go;
    wire nib_wr;
    wire nib_rd;
    wire stop_req;
    wire [7:0] next_blocks;
    wire flex_set;

    // Arguments that follow each command nibble
    function [3:0] arg_count;
        input [3:0] c;
        begin
            if (c == `CMD_RATE || c == `CMD_GAIN)
                arg_count = `ARGS_ONE;
            else if (c == `CMD_SELECT || c == `CMD_WBLK || c == `CMD_UWR)
                arg_count = `ARGS_BYTE;
            else if (c == `CMD_AWR)
                arg_count = `ARGS_HDR;
            else
                arg_count = `ARGS_NONE;
        end
    endfunction

    // ==========================================================
    // Index memory
    index_memory #(.AW(6), .DW(48), .UW(8)) u_mem
    (
        .clk_i(clk_i),
        .addr_i(mem_addr),
        .we_hdr_i(mem_we_hdr),
        .we_usr_i(mem_we_usr),
        .wdata_i(mem_wdata),
        .rdata_o(rdata)
    );

    // ==========================================================
    // Bus strobes; nibble writes are refused while the index is busy
    assign wb_go = cyc_i && stb_i && !ack_o;
    assign nib_wr = wb_go && we_i && sel_i[0] && adr_i == `REG_NIBBLE
        && state == S_IDLE && !go;
    assign nib_rd = wb_go && !we_i && adr_i == `REG_NIBBLE;
    assign stop_req = wb_go && we_i && sel_i[0] && adr_i == `REG_NIBBLE
        && dat_i[3:0] == `CMD_STOP;
    assign flex_set = cmd_set < `SET_DIRECT;
    assign next_blocks = blocks + {7'h00, block_done_i};
    // Busy covers every cycle the index memory is being walked
    assign busy_o = !(state == S_IDLE || state == S_TRIG || state == S_REC)
        || mem_we_hdr || go;

    // ==========================================================
    // Bus answer, registered one cycle after the request
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_o <= 1'b0;
            dat_o <= `ZERO_WORD;
        end
        else
        begin
            ack_o <= wb_go;
            if (wb_go && !we_i)
            begin
                if (adr_i == `REG_NIBBLE)
                    dat_o <= {28'h000_0000, (tx_left != 4'h0) ? tx_buf[3:0] : 4'h0};
                else if (adr_i == `REG_STATUS)
                    dat_o <= {20'h0_0000, tx_left, 2'h0, gain, cmd_set,
                        active_o, busy_o};
                else if (adr_i == `REG_SETUP)
                    dat_o <= {16'h0000, target, 2'h0, phrase};
                else
                    dat_o <= `ZERO_WORD;
            end
        end
    end

    // ==========================================================
    // Command nibble collection
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cmd <= 4'h0;
            args_left <= 4'h0;
            arg_idx <= 4'h0;
            arg <= `ZERO_HDR;
            go <= 1'b0;
        end
        else
        begin
            go <= 1'b0;
            if (nib_wr)
            begin
                if (args_left == 4'h0)
                begin
                    cmd <= dat_i[3:0];
                    args_left <= arg_count(dat_i[3:0]);
                    arg_idx <= 4'h0;
                    arg <= `ZERO_HDR;
                    go <= (arg_count(dat_i[3:0]) == `ARGS_NONE);
                end
                else
                begin
                    arg[4*arg_idx +: 4] <= dat_i[3:0];
                    arg_idx <= arg_idx + 4'h1;
                    args_left <= args_left - 4'h1;
                    go <= (args_left == 4'h1);
                end
            end
        end
    end

    // ==========================================================
    // Playback level; applies to the very next sample
    always @(posedge clk_i)
    begin
        if (rst_i)
            play_o <= 16'h0000;
        else if (gain == 2'h3)
            play_o <= sample_i >>> 2;
        else if (gain == 2'h2)
            play_o <= sample_i >>> 1;
        else
            play_o <= sample_i;
    end

    // ==========================================================
    // Main sequencer
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state <= S_IDLE;
            op <= OP_RBLK;
            cmd_set <= 2'h0;
            phrase <= 6'h00;
            target <= `ZERO_BYTE;
            gain <= 2'h0;
            armed <= 1'b0;
            tx_buf <= `ZERO_HDR;
            tx_left <= 4'h0;
            held <= `ZERO_HDR;
            free <= `ZERO_BYTE;
            blocks <= `ZERO_BYTE;
            addrc <= 16'h0000;
            mem_addr <= 6'h00;
            mem_we_hdr <= 1'b0;
            mem_we_usr <= 1'b0;
            mem_wdata <= 48'h0000_0000_0000;
            active_o <= 1'b0;
        end
        else
        begin
            mem_we_hdr <= 1'b0;
            mem_we_usr <= 1'b0;
            // Each nibble read hands out the next nibble, low first
            if (nib_rd && tx_left != 4'h0)
            begin
                tx_buf <= {4'h0, tx_buf[39:4]};
                tx_left <= tx_left - 4'h1;
            end
            case (state)
                S_IDLE:
                begin
                    if (go)
                    begin
                        if (cmd == `CMD_RATE)
                            cmd_set <= arg[1:0];
                        else if (cmd == `CMD_SELECT)
                            phrase <= arg[5:0];
                        else if (cmd == `CMD_WBLK && flex_set)
                            target <= arg[7:0];
                        else if (cmd == `CMD_GAIN)
                            gain <= arg[1:0];
                        else if (cmd == `CMD_CAPTURE)
                            armed <= 1'b1;
                        else if (cmd == `CMD_RBLK && flex_set)
                        begin
                            op <= OP_RBLK;
                            mem_addr <= phrase;
                            state <= S_MRD;
                        end
                        else if (cmd == `CMD_ARD)
                        begin
                            op <= OP_ARD;
                            mem_addr <= phrase;
                            state <= S_MRD;
                        end
                        else if (cmd == `CMD_AWR)
                        begin
                            // Header only; user data in the entry survives
                            mem_addr <= phrase;
                            mem_wdata <= {`ZERO_BYTE, arg};
                            mem_we_hdr <= 1'b1;
                            state <= S_WRT;
                        end
                        else if (cmd == `CMD_UWR)
                        begin
                            mem_addr <= phrase;
                            mem_wdata <= {arg[7:0], `ZERO_HDR};
                            mem_we_usr <= 1'b1;
                            state <= S_WRT;
                        end
                        else if (cmd == `CMD_ERASE && phrase == `CH_FREE)
                        begin
                            mem_addr <= `CH_FREE;
                            state <= S_ERALL;
                        end
                        else if (cmd == `CMD_ERASE)
                        begin
                            op <= OP_DEL;
                            mem_addr <= phrase;
                            state <= S_MRD;
                        end
                        else if (cmd == `CMD_START && armed && flex_set
                            && phrase != `CH_FREE)
                        begin
                            // Free count is fetched first so the end test is local
                            op <= OP_REC;
                            mem_addr <= `CH_FREE;
                            active_o <= 1'b1;
                            armed <= 1'b0;
                            state <= S_MRD;
                        end
                    end
                end
                S_MRD:
                    state <= S_MRDW;
                S_MRDW:
                begin
                    held <= rdata[`HDR_BITS];
                    if (op == OP_RBLK)
                    begin
                        // ch00 holds the unused count in the same field
                        tx_buf <= {32'h0000_0000, rdata[`F_COUNT]};
                        tx_left <= `ARGS_BYTE;
                        state <= S_IDLE;
                    end
                    else if (op == OP_ARD)
                    begin
                        tx_buf <= rdata[`HDR_BITS];
                        tx_left <= `ARGS_HDR;
                        state <= S_IDLE;
                    end
                    else if (op == OP_DEL)
                    begin
                        blocks <= rdata[`F_COUNT];
                        op <= OP_DEL2;
                        mem_addr <= `CH_FREE;
                        state <= S_MRD;
                    end
                    else if (op == OP_DEL2)
                        state <= S_DEL2;
                    else
                    begin
                        free <= rdata[`F_COUNT];
                        blocks <= `ZERO_BYTE;
                        addrc <= 16'h0000;
                        state <= S_TRIG;
                    end
                end
                S_DEL2:
                begin
                    // Return the phrase's blocks to the unused pool
                    mem_wdata <= {`ZERO_BYTE, held[`F_UPPER],
                        held[`F_COUNT] + blocks};
                    mem_we_hdr <= 1'b1;
                    state <= S_DELZ;
                end
                S_DELZ:
                begin
                    mem_addr <= phrase;
                    mem_wdata <= 48'h0000_0000_0000;
                    mem_we_hdr <= 1'b1;
                    mem_we_usr <= 1'b1;
                    state <= S_WRT;
                end
                S_WRT:
                    state <= S_IDLE;
                S_ERALL:
                begin
                    // Walks every entry, header and user data alike
                    mem_we_hdr <= 1'b1;
                    mem_we_usr <= 1'b1;
                    if (mem_we_hdr)
                        mem_addr <= mem_addr + 6'h01;
                    if (mem_we_hdr && mem_addr == `CH_FREE)
                        mem_wdata <= 48'h0000_0000_0000;
                    else if (!mem_we_hdr)
                        mem_wdata <= {`ZERO_BYTE, 32'h0000_0000, FREE_INIT};
                    if (mem_we_hdr && mem_addr == `CH_LAST)
                    begin
                        mem_we_hdr <= 1'b0;
                        mem_we_usr <= 1'b0;
                        state <= S_IDLE;
                    end
                end
                S_TRIG:
                begin
                    // Stop while waiting leaves the phrase empty
                    if (stop_req)
                        state <= S_RECE;
                    else if (voice_i)
                        state <= S_REC;
                end
                S_REC:
                begin
                    blocks <= next_blocks;
                    if (sample_tick_i)
                        addrc <= addrc + 16'h0001;
                    if (stop_req || next_blocks == target || next_blocks == free)
                        state <= S_RECE;
                end
                S_RECE:
                begin
                    mem_addr <= phrase;
                    mem_wdata <= {`ZERO_BYTE, `ZERO_BYTE, blocks, addrc[7:0],
                        addrc[15:8], blocks};
                    mem_we_hdr <= 1'b1;
                    state <= S_RECF;
                end
                S_RECF:
                begin
                    mem_addr <= `CH_FREE;
                    mem_wdata <= {`ZERO_BYTE, held[`F_UPPER], free - blocks};
                    mem_we_hdr <= 1'b1;
                    active_o <= 1'b0;
                    state <= S_WRT;
                end
                default:
                    state <= S_IDLE;
            endcase
        end
    end
endmodule // phrase_index_unit

// File: logic/phrase_index_consts.vh
// Constants for the phrase index command unit
// Functional notes
// - Read-block-count returns the phrase's 8-bit count as two nibbles on two reads.
// - With ch00 selected the count returned is the unused block count.
// - With ch01 to ch3F selected the count returned is that phrase's blocks.
// - Address write stores host start and stop addresses in the index entry.
// - Address transfers move a 40-bit header as ten nibbles, low first.
// - Flex header nibbles: count, stop row, stop column, stop block, earlier block.
// - Gain code 00/01 full, 10 half, 11 quarter amplitude.
// - A gain command takes effect at once, even during playback.
// - Reset returns gain to full amplitude.
// - Erase with ch00 zeroes ch01 to ch3F and initialises ch00.
// - Erase all also clears every user data field.
// - Erasing one phrase zeroes its entry and returns its blocks to ch00.
// - Recording ends alone at the programmed count or when blocks run out.
// - Stop saves block counter and address counter into the phrase entry.
// - Active flag is set during trigger wait and recording, clear after.
`ifndef PHRASE_INDEX_CONSTS_VH
`define PHRASE_INDEX_CONSTS_VH
// ==========================================================
// Register offsets
`define REG_NIBBLE 8'h00
`define REG_STATUS 8'h04
`define REG_SETUP 8'h08
// ==========================================================
// Command nibbles
`define CMD_RATE 4'h1
`define CMD_SELECT 4'h2
`define CMD_WBLK 4'h3
`define CMD_RBLK 4'h4
`define CMD_GAIN 4'h5
`define CMD_ERASE 4'h6
`define CMD_CAPTURE 4'h7
`define CMD_AWR 4'h8
`define CMD_ARD 4'h9
`define CMD_START 4'hA
`define CMD_STOP 4'hB
`define CMD_UWR 4'hC
// ==========================================================
// Argument nibble counts
`define ARGS_NONE 4'h0
`define ARGS_ONE 4'h1
`define ARGS_BYTE 4'h2
`define ARGS_HDR 4'hA
// ==========================================================
// Index entry layout: header in 39:0, user data in 47:40
`define HDR_BITS 39:0
`define USR_BITS 47:40
`define F_COUNT 7:0
`define F_UPPER 39:8
`define CH_FREE 6'h00
`define CH_LAST 6'h3F
`define SET_DIRECT 2'h2
`define ZERO_BYTE 8'h00
`define ZERO_HDR 40'h00_0000_0000
`define ZERO_WORD 32'h0000_0000
`endif

// File: logic/index_memory.v
// Channel index memory with registered read data
`timescale 1ns/1ns
module index_memory
#(
    parameter AW = 6,
    parameter DW = 48,
    parameter UW = 8
)
(
    input wire clk_i,
    input wire [AW-1:0] addr_i,
    input wire we_hdr_i,
    input wire we_usr_i,
    input wire [DW-1:0] wdata_i,
    output reg [DW-1:0] rdata_o
);
    reg [DW-1:0] mem [0:(1<<AW)-1];

    // ==========================================================
    // Write by field, read one cycle later
    always @(posedge clk_i)
    begin
        if (we_hdr_i)
            mem[addr_i][DW-UW-1:0] <= wdata_i[DW-UW-1:0];
        if (we_usr_i)
            mem[addr_i][DW-1:DW-UW] <= wdata_i[DW-1:DW-UW];
        rdata_o <= mem[addr_i];
    end
endmodule // index_memory

// File: test/phrase_index_unit_properties.sv
// Port checker for the phrase index command unit
`timescale 1ns/1ns
`include "phrase_index_consts.vh"
module phrase_index_checker
#(
    parameter FREE_INIT = 8'hFE
)
(
    input wire clk_i,
    input wire rst_i,
    input wire cyc_i,
    input wire stb_i,
    input wire we_i,
    input wire [7:0] adr_i,
    input wire [31:0] dat_i,
    input wire [31:0] dat_o,
    input wire ack_o,
    input wire busy_o,
    input wire active_o,
    input wire block_done_i,
    input wire signed [15:0] sample_i,
    input wire signed [15:0] play_o
);
    // ====================
    // Helper state
    reg [3:0] last_nib;
    reg [7:0] since_done;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Last nibble taken, and cycles since a block filled; saturates so it never wraps
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            last_nib <= 4'h0;
            since_done <= 8'hFF;
        end
        else
        begin
            if (cyc_i && stb_i && !ack_o && we_i && adr_i == `REG_NIBBLE)
            begin
                last_nib <= dat_i[3:0];
            end
            if (block_done_i)
            begin
                since_done <= 8'h00;
            end
            else if (since_done != 8'hFF)
            begin
                since_done <= since_done + 8'h01;
            end
        end
    end
    // ====================
    // Properties
    chk_reset_quiet: assert property (
        $fell(rst_i) |-> play_o == 16'sh0000 && !active_o && !ack_o)
        else $error("outputs not quiet after reset");
    chk_full_after_reset: assert property (
        $fell(rst_i) |=> play_o == $past(sample_i))
        else $error("gain not full after reset");
    chk_play_scale: assert property (
        !$past(rst_i) |-> play_o == $past(sample_i) || play_o == ($past(sample_i) >>> 1)
        || play_o == ($past(sample_i) >>> 2))
        else $error("playback level not a legal scale");
    chk_ack_once: assert property (
        cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
        else $error("bus answer not a single pulse");
    chk_busy_held: assert property (
        $rose(busy_o) && (last_nib == `CMD_RBLK || last_nib == `CMD_ARD) |=> busy_o [*2])
        else $error("busy dropped during access");
    chk_busy_bounded: assert property (
        busy_o |-> ##[1:1000] !busy_o)
        else $error("busy never released");
    chk_active_start: assert property (
        $rose(active_o) |-> last_nib == `CMD_START)
        else $error("active rose without start");
    chk_active_end: assert property (
        $fell(active_o) |-> last_nib == `CMD_STOP || since_done < 8'h28)
        else $error("active fell without cause");
    chk_status_flags: assert property (
        ack_o && !we_i && adr_i == `REG_STATUS |-> dat_o[1:0] == {$past(active_o), $past(busy_o)})
        else $error("status flags wrong");
    cover property ($rose(active_o));
    cover property ($fell(busy_o));
    cover property (ack_o && !we_i && adr_i == `REG_STATUS);
endmodule // phrase_index_checker

bind phrase_index_unit phrase_index_checker #(.FREE_INIT(FREE_INIT)) chk_u
(
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .busy_o(busy_o), .active_o(active_o),
    .block_done_i(block_done_i), .sample_i(sample_i), .play_o(play_o)
);

// File: test/phrase_host_model.sv
// Host controller model speaking nibble commands over classic Wishbone
`timescale 1ns/1ns
`include "phrase_index_consts.vh"
module phrase_host_model
(
    input wire clk_i,
    input wire ack_i,
    input wire [31:0] dat_i,
    input wire busy_i,
    output reg cyc_o = 1'b0,
    output reg stb_o = 1'b0,
    output reg we_o = 1'b0,
    output reg [7:0] adr_o = 8'h00,
    output reg [3:0] sel_o = 4'h0,
    output reg [31:0] dat_o = 32'h0000_0000
);
    // ====================
    // One bus cycle; idle address and data lines show the inverse so stale values never pass
    task bus(input reg w, input reg [7:0] a, input reg [31:0] d, output reg [31:0] q);
    begin
        cyc_o <= 1'b1;
        stb_o <= 1'b1;
        we_o <= w;
        adr_o <= a;
        sel_o <= 4'h1;
        dat_o <= d;
        @(posedge clk_i);
        // No cycle limit of its own; the bench watchdog ends a hang
        while (ack_i !== 1'b1)
            @(posedge clk_i);
        q = dat_i;
        cyc_o <= 1'b0;
        stb_o <= 1'b0;
        sel_o <= 4'h0;
        adr_o <= ~a;
        dat_o <= ~d;
        @(posedge clk_i);
    end
    endtask
    // Wait out busy before anything else reaches the unit
    task wait_idle;
    begin
        @(posedge clk_i);
        while (busy_i !== 1'b0)
            @(posedge clk_i);
    end
    endtask
    // Command nibble then its arguments, low nibble first
    task send(input reg [3:0] cmd, input integer cnt, input reg [39:0] val);
        integer k;
        reg [31:0] q;
    begin
        bus(1'b1, `REG_NIBBLE, {28'h0, cmd}, q);
        wait_idle;
        for (k = 0; k < cnt; k = k + 1)
        begin
            bus(1'b1, `REG_NIBBLE, {28'h0, val[4*k +: 4]}, q);
            wait_idle;
        end
    end
    endtask
    task read_nibs(input integer cnt, output reg [39:0] v);
        integer k;
        reg [31:0] q;
    begin
        v = 40'h0;
        for (k = 0; k < cnt; k = k + 1)
        begin
            bus(1'b0, `REG_NIBBLE, 32'h0, q);
            v[4*k +: 4] = q[3:0];
            wait_idle;
        end
    end
    endtask
    task erase_all;
    begin
        send(`CMD_RATE, 1, 40'h0);
        send(`CMD_SELECT, 2, 40'h0);
        send(`CMD_ERASE, 0, 40'h0);
    end
    endtask
    task record(input reg [7:0] ph, input reg [7:0] n);
    begin
        send(`CMD_RATE, 1, 40'h0);
        send(`CMD_SELECT, 2, {32'h0, ph});
        send(`CMD_WBLK, 2, {32'h0, n});
        send(`CMD_CAPTURE, 0, 40'h0);
        send(`CMD_START, 0, 40'h0);
    end
    endtask
endmodule // phrase_host_model

// File: test/test_phrase_index_unit.sv
// Self-checking bench for the phrase index command unit
`timescale 1ns/1ns
`include "phrase_index_consts.vh"
module test_phrase_index_unit;
    // Small free count so running out of blocks is cheap to reach
    localparam [7:0] FREE = 8'h03;
    localparam [39:0] HDR = 40'h00_7E_C3_5A_09;
    // Direct ROM header: the two dummy upper column nibbles are zero
    localparam [39:0] HDR_ROM = 40'h0C_A1_05_2E_71;
    reg clk = 1'b0;
    reg rst = 1'b1;
    reg voice = 1'b1;
    reg done = 1'b0;
    reg tick = 1'b0;
    reg signed [15:0] sample = 16'sh4000;
    wire cyc, stb, we, ack, busy, active;
    wire [7:0] adr;
    wire [3:0] sel;
    wire [31:0] wdat;
    wire [31:0] rdat;
    wire signed [15:0] play;
    integer bad_count = 0;
    integer checks = 0;
    reg [39:0] got;
    // ====================
    // Clock, unit and host
    always #50 clk = ~clk;
    phrase_index_unit #(.FREE_INIT(FREE)) dut_u
    (
        .clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
        .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .busy_o(busy),
        .active_o(active), .voice_i(voice), .block_done_i(done), .sample_tick_i(tick),
        .sample_i(sample), .play_o(play)
    );
    phrase_host_model host_u
    (
        .clk_i(clk), .ack_i(ack), .dat_i(rdat), .busy_i(busy), .cyc_o(cyc), .stb_o(stb),
        .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat)
    );
    // ====================
    // Shared tasks
    task expect_val(input [39:0] g, input [39:0] e);
    begin
        checks = checks + 1;
        if (g !== e)
        begin
            bad_count = bad_count + 1;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    end
    endtask
    task stop_test;
    begin
        if (bad_count == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    end
    endtask
    task read_count(input [7:0] ph, input [39:0] e);
    begin
        host_u.send(`CMD_SELECT, 2, {32'h0, ph});
        host_u.send(`CMD_RBLK, 0, 40'h0);
        host_u.read_nibs(2, got);
        expect_val(got, e);
    end
    endtask
    task wait_active(input v);
        integer n;
    begin
        n = 0;
        while (active !== v && n < 100)
        begin
            n = n + 1;
            @(posedge clk);
        end
        expect_val({39'h0, active}, {39'h0, v});
        if (!v)
            host_u.wait_idle;
    end
    endtask
    // Each block filled is followed by one address step
    task pulse(input integer cnt);
    begin
        repeat (cnt)
        begin
            done <= 1'b1;
            @(posedge clk);
            done <= 1'b0;
            tick <= 1'b1;
            @(posedge clk);
            tick <= 1'b0;
        end
    end
    endtask
    // ====================
    // Scenarios
    task t_reset;
    begin
        host_u.bus(1'b0, `REG_STATUS, 32'h0, got[31:0]);
        expect_val(play, 40'h4000);
        expect_val(got[5:0], 40'h0);
        host_u.bus(1'b0, 8'h40, 32'h0, got[31:0]);
        expect_val(got[31:0], 40'h0);
    end
    endtask
    task t_gain;
        integer g;
    begin
        for (g = 3; g >= 0; g = g - 1)
        begin
            host_u.send(`CMD_GAIN, 1, g);
            expect_val(play, 40'h4000 >> (g == 0 ? 0 : g - 1));
        end
    end
    endtask
    task t_erase_all;
    begin
        host_u.erase_all;
        read_count(8'h00, FREE);
        read_count(8'h05, 40'h0);
    end
    endtask
    task t_address;
    begin
        host_u.send(`CMD_SELECT, 2, 40'h5);
        host_u.bus(1'b0, `REG_SETUP, 32'h0, got[31:0]);
        expect_val(got[15:0], 40'h0005);
        host_u.send(`CMD_AWR, 10, HDR);
        host_u.send(`CMD_ARD, 0, 40'h0);
        host_u.read_nibs(10, got);
        expect_val(got, HDR);
        read_count(8'h05, HDR[7:0]);
        host_u.send(`CMD_RATE, 1, `SET_DIRECT);
        host_u.send(`CMD_SELECT, 2, 40'h3F);
        host_u.send(`CMD_AWR, 10, HDR_ROM);
        host_u.send(`CMD_ARD, 0, 40'h0);
        host_u.read_nibs(10, got);
        expect_val(got, HDR_ROM);
    end
    endtask
    task t_record;
    begin
        host_u.record(8'h03, 8'h02);
        wait_active(1'b1);
        pulse(2);
        wait_active(1'b0);
        read_count(8'h03, 40'h2);
        read_count(8'h00, FREE - 8'h02);
        host_u.send(`CMD_SELECT, 2, 40'h3);
        host_u.send(`CMD_ERASE, 0, 40'h0);
        read_count(8'h03, 40'h0);
        read_count(8'h00, FREE);
    end
    endtask
    task t_run_out;
    begin
        host_u.record(8'h06, 8'h05);
        wait_active(1'b1);
        pulse(3);
        wait_active(1'b0);
        read_count(8'h06, FREE);
        read_count(8'h00, 40'h0);
    end
    endtask
    task t_stop;
    begin
        host_u.record(8'h04, 8'h05);
        wait_active(1'b1);
        pulse(1);
        host_u.send(`CMD_STOP, 0, 40'h0);
        wait_active(1'b0);
        host_u.send(`CMD_ARD, 0, 40'h0);
        host_u.read_nibs(10, got);
        expect_val({got[39:24], got[7:0]}, 40'h00_01_01);
    end
    endtask
    // ====================
    // Main sequence and watchdog
    initial
    begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset;
        t_gain;
        t_erase_all;
        t_address;
        t_record;
        t_run_out;
        t_erase_all;
        t_stop;
        stop_test;
    end
    initial
    begin
        #3000000;
        bad_count = bad_count + 1;
        stop_test;
    end
endmodule // test_phrase_index_unit
